// file: design/vidr_pkg.sv
package vidr_pkg;
	// response identity and fixed codes
	localparam logic [7:0] VIDR_RESP_TYPE = 8'h95;
	localparam logic [7:0] VIDR_REQ_TYPE = 8'h15;
	localparam logic [15:0] VIDR_CODE_OK = 16'h0000;
	localparam logic [15:0] VIDR_REASON_NONE = 16'h0000;
	// protocol compatibility version, BCD with single-digit marker
	localparam logic [7:0] VIDR_VER_MAJOR = 8'hf1;
	localparam logic [7:0] VIDR_VER_MINOR = 8'hf2;
	localparam logic [7:0] VIDR_VER_UPDATE = 8'hf0;
	localparam logic [7:0] VIDR_SFX_FIRST = 8'h00;
	localparam logic [7:0] VIDR_SFX_SECOND = 8'h00;
	localparam logic [7:0] VIDR_SFX_UNUSED = 8'h00;
	localparam logic [7:0] VIDR_NO_UPDATE = 8'hff;
	localparam logic [3:0] VIDR_BCD_SINGLE = 4'hf;
	localparam logic [3:0] VIDR_BCD_MAX = 4'h9;
	localparam logic [23:0] VIDR_RSVD = 24'h000000;
	// identifier defaults
	localparam logic [15:0] VIDR_PCI_NONE = 16'h0000;
	localparam logic [31:0] VIDR_MAKER_UNUSED = 32'hffffffff;
	// frame geometry: bytes 16..59 leave the builder, header is added elsewhere
	localparam logic [5:0] VIDR_FIRST_BYTE = 6'h10;
	localparam logic [5:0] VIDR_FRAME_BYTES = 6'h2c;
	localparam int VIDR_SUM_WORDS = 20;
	localparam int VIDR_NAME_BYTES = 12;
	localparam int VIDR_FIFO_DEPTH = 32;
	localparam int VIDR_NFUNC = 8;

	typedef struct packed {
		logic [15:0] did;
		logic [15:0] vid;
		logic [15:0] ssid;
		logic [15:0] svid;
	} vidr_pci_type;

	// field order equals wire order, most significant first
	typedef struct packed {
		logic [15:0] resp_code;
		logic [15:0] reason_code;
		logic [7:0] major;
		logic [7:0] minor;
		logic [7:0] update;
		logic [7:0] first_suffix_char;
		logic [23:0] rsvd;
		logic [7:0] second_suffix_char;
		logic [95:0] fw_name;
		logic [31:0] fw_version;
		vidr_pci_type pci;
		logic [31:0] maker_enterprise_number;
		logic [31:0] checksum;
	} vidr_frame_type;

	typedef enum logic [0:0] {
		VIDR_IDLE = 1'b0,
		VIDR_SEND = 1'b1
	} vidr_state_type;
endpackage : vidr_pkg

// file: design/vidr_builder.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// byte fifo with honest full and empty; read side is a plain array lookup
module vidr_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	wire logic full_w = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire logic empty_w = (wr_q == rd_q);
	wire logic push_w = in_valid && !full_w;
	wire logic pop_w = out_valid && out_ready;

	assign in_ready = !full_w;
	assign out_valid = !empty_w;
	assign out_data = mem_q[rd_q[AW-1:0]];

	// pointers carry a wrap bit so full and empty never alias
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push_w) wr_q <= wr_q + 1'b1;
			if (pop_w) rd_q <= rd_q + 1'b1;
		end
	end

	// storage needs no reset, pointers guard it
	always_ff @(posedge clk) begin
		if (push_w) mem_q[wr_q[AW-1:0]] <= in_data;
	end
endmodule : vidr_fifo

////////////////////////////////////////////////////////////////////////////////
// How it works
// (RULE1) every accepted request gets one response of type 0x95, no own reason code
// (RULE2) version word at 20-23, second suffix low in 24-27, name at 28-39
// (RULE3) fw version 40-43 MSB first, PCI ids 44-51, maker 52-55, checksum 56-59
// (RULE4) major, minor and update bytes are packed two-digit BCD
// (RULE5) suffix bytes are Latin-1 or zero; second only used after first
// (RULE6) upper nibble 0xF marks a single-digit BCD byte; receiver ignores it
// (RULE7) update 0xFF means absent; major and minor never carry 0xFF
// (RULE8) reported version is major 0xF1, minor 0xF2, update 0xF0, suffixes zero
// (RULE9) firmware name is left-justified, first character in most significant byte
// (RULE10) short name ends with a zero byte; bytes after it are don't care
// (RULE11) firmware version is a vendor-chosen 32-bit value of four point bytes
// (RULE12) with no shared host interface all four PCI ids are zero
// (RULE13) with a shared host interface the ids are that interface's
// (RULE14) with several functions, report the lowest-numbered assigned function
// (RULE15) the requester sends command 0x15 carrying header, checksum and padding only
// (RULE16) maker number is a 32-bit binary value, all ones when unused
// (RULE17) fields come from static inputs, sent in field order, checksum last
module vidr_builder
	import vidr_pkg::*;
#(
	parameter int NFUNC = VIDR_NFUNC,
	parameter int FIFO_DEPTH = VIDR_FIFO_DEPTH
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic REQUEST,
	input wire logic REQ_FAIL,
	input wire logic [15:0] FAIL_CODE,
	input wire logic [15:0] FAIL_REASON,
	input wire logic [95:0] FW_NAME,
	input wire logic [31:0] FW_VERSION,
	input wire logic HOST_PCI_SHARED,
	input wire logic [NFUNC-1:0] FUNC_ASSIGNED,
	input wire vidr_pci_type [NFUNC-1:0] FUNC_PCI_IDS,
	input wire logic MAKER_VALID,
	input wire logic [31:0] MAKER_NUMBER,
	input wire logic [31:0] HEADER_SUM,
	input wire logic OUT_READY,
	output logic OUT_VALID,
	output logic [7:0] OUT_DATA,
	output logic OUT_LAST,
	output logic [7:0] RESP_TYPE,
	output logic BUSY
);
	localparam int FW = $clog2(NFUNC);

	// lowest set bit of the assignment mask; zero when nothing is assigned
	function automatic logic [FW-1:0] lowest_func(input logic [NFUNC-1:0] mask);
		logic [FW-1:0] idx;
		idx = '0;
		for (int i = NFUNC - 1; i >= 0; i--) begin
			if (mask[i]) idx = FW'(i);
		end
		return idx;
	endfunction : lowest_func

	// legal packed BCD byte, single-digit form allowed
	function automatic logic is_bcd(input logic [7:0] b);
		return (b[3:0] <= VIDR_BCD_MAX) && ((b[7:4] <= VIDR_BCD_MAX) || (b[7:4] == VIDR_BCD_SINGLE));
	endfunction : is_bcd

	// two's complement of the 16-bit word sum, seeded with the header sum the caller passes
	function automatic logic [31:0] frame_sum(input logic [319:0] body, input logic [31:0] hdr);
		logic [31:0] s;
		s = hdr;
		for (int i = 0; i < VIDR_SUM_WORDS; i++) begin
			s = s + {16'h0000, body[i*16 +: 16]};
		end
		return (~s) + 32'h00000001;
	endfunction : frame_sum

	vidr_state_type state_q;
	vidr_state_type state_d;
	vidr_frame_type frame_q;
	vidr_frame_type frame_w;
	logic [5:0] cnt_q;
	logic out_valid_q;
	logic [7:0] out_data_q;
	logic out_last_q;
	logic [7:0] resp_type_q;
	logic busy_q;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [8:0] fifo_out_data;

	////////////////////////////////////////////////////////////////////////////////
	// field assembly from static configuration
	wire logic [FW-1:0] func_sel = lowest_func(FUNC_ASSIGNED); // RULE14
	wire vidr_pci_type pci_none_w = vidr_pci_type'({4{VIDR_PCI_NONE}}); // RULE12
	wire vidr_pci_type pci_sel = HOST_PCI_SHARED ? FUNC_PCI_IDS[func_sel] : pci_none_w; // RULE13
	// second suffix is forced unused while the first is unused
	wire logic [7:0] sfx2_w = (VIDR_SFX_FIRST == VIDR_SFX_UNUSED) ? VIDR_SFX_UNUSED : VIDR_SFX_SECOND; // RULE5
	wire logic [31:0] maker_w = MAKER_VALID ? MAKER_NUMBER : VIDR_MAKER_UNUSED; // RULE16

	always_comb begin
		frame_w.resp_code = REQ_FAIL ? FAIL_CODE : VIDR_CODE_OK; // RULE1
		frame_w.reason_code = REQ_FAIL ? FAIL_REASON : VIDR_REASON_NONE; // RULE1
		frame_w.major = VIDR_VER_MAJOR; // RULE8 RULE4 RULE6 RULE7
		frame_w.minor = VIDR_VER_MINOR; // RULE8 RULE4 RULE6 RULE7
		frame_w.update = VIDR_VER_UPDATE; // RULE8 RULE4
		frame_w.first_suffix_char = VIDR_SFX_FIRST; // RULE8 RULE5
		frame_w.rsvd = VIDR_RSVD; // RULE2
		frame_w.second_suffix_char = sfx2_w; // RULE2
		frame_w.fw_name = FW_NAME; // RULE9 RULE10
		frame_w.fw_version = FW_VERSION; // RULE11 RULE3
		frame_w.pci = pci_sel; // RULE3
		frame_w.maker_enterprise_number = maker_w; // RULE3
		frame_w.checksum = 32'h00000000;
		frame_w.checksum = frame_sum(frame_w[351:32], HEADER_SUM); // RULE3
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer: snapshot on request, then shift out one byte per fifo slot
	wire logic push_valid = (state_q == VIDR_SEND);
	wire logic push_fire = push_valid && fifo_in_ready;
	wire logic push_last = (cnt_q == 6'h01);
	wire logic [7:0] push_byte = frame_q[351:344];
	wire logic take_req = (state_q == VIDR_IDLE) && REQUEST; // RULE1

	always_comb begin
		case (state_q)
			VIDR_IDLE: state_d = take_req ? VIDR_SEND : VIDR_IDLE;
			VIDR_SEND: state_d = (push_fire && push_last) ? VIDR_IDLE : VIDR_SEND;
			default: state_d = VIDR_IDLE;
		endcase
	end

	// a request during a response is dropped; the requester retries on timeout
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			state_q <= VIDR_IDLE;
			cnt_q <= 6'h00;
			frame_q <= '0;
		end else begin
			state_q <= state_d;
			if (take_req) begin
				frame_q <= frame_w; // RULE17
				cnt_q <= VIDR_FRAME_BYTES;
			end else if (push_fire) begin
				frame_q <= frame_q << 8; // RULE17
				cnt_q <= cnt_q - 6'h01;
			end
		end
	end

	// output flop takes a new byte whenever it is empty or being drained
	wire logic pop_ready = !out_valid_q || OUT_READY;

	vidr_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLOCK),
		.rst(RESET),
		.in_valid(push_valid),
		.in_ready(fifo_in_ready),
		.in_data({push_last, push_byte}),
		.out_valid(fifo_out_valid),
		.out_ready(pop_ready),
		.out_data(fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// registered output stage so every port comes from a flop
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			out_valid_q <= 1'b0;
			out_data_q <= 8'h00;
			out_last_q <= 1'b0;
		end else if (pop_ready) begin
			out_valid_q <= fifo_out_valid;
			out_data_q <= fifo_out_data[7:0];
			out_last_q <= fifo_out_data[8] && fifo_out_valid;
		end
	end

	// type is constant for this builder; busy covers framing only, not fifo drain
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			resp_type_q <= 8'h00;
			busy_q <= 1'b0;
		end else begin
			resp_type_q <= VIDR_RESP_TYPE; // RULE1
			busy_q <= (state_d == VIDR_SEND);
		end
	end

	assign OUT_VALID = out_valid_q;
	assign OUT_DATA = out_data_q;
	assign OUT_LAST = out_last_q;
	assign RESP_TYPE = resp_type_q;
	assign BUSY = busy_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	sequence s_load;
		(state_q == VIDR_IDLE) && REQUEST;
	endsequence
	sequence s_first;
		(state_q == VIDR_SEND) && (cnt_q == VIDR_FRAME_BYTES);
	endsequence

	req_accept_a: assert property (s_load |=> s_first) // RULE1
		else $error("request not taken into a full frame");
	resp_type_a: assert property ($past(RESET) == 1'b0 |-> RESP_TYPE == 8'h95) // RULE1
		else $error("response type is not 0x95");
	ver_bcd_a: assert property (s_load |=> is_bcd(frame_q.major) && is_bcd(frame_q.minor) && is_bcd(frame_q.update)) // RULE4
		else $error("version byte is not packed BCD");
	ver_value_a: assert property (s_load |=> {frame_q.major, frame_q.minor, frame_q.update,
		frame_q.first_suffix_char, frame_q.second_suffix_char} == 40'hf1f2f00000) // RULE8
		else $error("reported version differs from 1.2.0");
	no_ff_a: assert property (s_load |=> frame_q.major != 8'hff && frame_q.minor != 8'hff) // RULE7
		else $error("0xFF in major or minor");
	sfx_order_a: assert property (s_load |=> frame_q.first_suffix_char != 8'h00
		|| frame_q.second_suffix_char == 8'h00) // RULE5
		else $error("second suffix used before first");
	name_just_a: assert property (s_load |=> frame_q.fw_name == $past(FW_NAME) && frame_q.rsvd == 24'h0) // RULE9
		else $error("name field not taken as given");
	pci_zero_a: assert property ((s_load and (!HOST_PCI_SHARED)) |=> frame_q.pci == 64'h0) // RULE12
		else $error("pci ids not zero without a shared host interface");
	pci_low_a: assert property ((s_load and (HOST_PCI_SHARED && FUNC_ASSIGNED[0])) |=>
		frame_q.pci == $past(FUNC_PCI_IDS[0])) // RULE14
		else $error("pci ids not from lowest assigned function");
	maker_a: assert property ((s_load and (!MAKER_VALID)) |=> frame_q.maker_enterprise_number == 32'hffffffff) // RULE16
		else $error("unused maker number not all ones");
	order_a: assert property ((s_first and fifo_in_ready) |-> push_byte == frame_q.resp_code[15:8] ##1 push_valid) // RULE17
		else $error("first byte is not response code high");
	last_byte_a: assert property (push_fire && push_last |=> state_q == VIDR_IDLE) // RULE3
		else $error("frame did not end after checksum byte");
endmodule : vidr_builder

// file: sim/vidr_sink.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// far-side receiver: takes bytes with a chosen ready pattern and keeps them raw
module vidr_sink (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic [1:0] MODE,
	input wire logic OUT_VALID,
	input wire logic [7:0] OUT_DATA,
	input wire logic OUT_LAST,
	output logic OUT_READY = 1'b0
);
	logic [7:0] got [0:255];
	int cnt = 0;
	int last_at = -1;
	logic phase = 1'b0;
	// ready pattern: 0 prompt, 1 held off, 2 every other cycle; changes just after the edge
	always @(posedge CLOCK) begin
		phase <= RESET ? 1'b0 : ~phase;
		OUT_READY <= #1 (MODE == 2'h0) || (MODE == 2'h2 && phase);
	end
	// bytes kept unparsed; bcd nibbles and bytes past the name terminator are left to the reader
	always @(posedge CLOCK) begin
		if (RESET) begin
			cnt <= 0;
		end else if (OUT_VALID === 1'b1 && OUT_READY) begin
			got[cnt] <= OUT_DATA;
			if (OUT_LAST === 1'b1) begin
				last_at <= cnt;
			end
			cnt <= cnt + 1;
		end
	end
endmodule : vidr_sink

// file: sim/tb.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// bench: requests are pulses after the edge, frames checked byte by byte at the sink
module tb;
	import vidr_pkg::*;
	logic CLOCK, RESET, REQUEST, REQ_FAIL, HOST_PCI_SHARED, MAKER_VALID;
	logic [15:0] FAIL_CODE, FAIL_REASON;
	logic [95:0] FW_NAME;
	logic [31:0] FW_VERSION, MAKER_NUMBER, HEADER_SUM;
	logic [7:0] FUNC_ASSIGNED, RESP_TYPE, OUT_DATA;
	vidr_pci_type [7:0] FUNC_PCI_IDS;
	logic OUT_READY, OUT_VALID, OUT_LAST, BUSY;
	logic [1:0] mode;
	int num_errors = 0;
	int checks = 0;
	int base = 0;
	vidr_builder vidr_builder_inst (.CLOCK(CLOCK), .RESET(RESET), .REQUEST(REQUEST), .REQ_FAIL(REQ_FAIL),
		.FAIL_CODE(FAIL_CODE), .FAIL_REASON(FAIL_REASON), .FW_NAME(FW_NAME), .FW_VERSION(FW_VERSION),
		.HOST_PCI_SHARED(HOST_PCI_SHARED), .FUNC_ASSIGNED(FUNC_ASSIGNED), .FUNC_PCI_IDS(FUNC_PCI_IDS),
		.MAKER_VALID(MAKER_VALID), .MAKER_NUMBER(MAKER_NUMBER), .HEADER_SUM(HEADER_SUM), .OUT_READY(OUT_READY),
		.OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST), .RESP_TYPE(RESP_TYPE), .BUSY(BUSY));
	vidr_sink vidr_sink_inst (.CLOCK(CLOCK), .RESET(RESET), .MODE(mode), .OUT_VALID(OUT_VALID),
		.OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST), .OUT_READY(OUT_READY));
	////////////////////////////////////////////////////////////////////////////////
	// 5 ns clock
	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check8
	task automatic check_cnt(input string what, input int exp, input int seen);
		checks++;
		if (seen != exp) begin
			num_errors++;
			$display("BAD %s expected %0d seen %0d", what, exp, seen);
		end
	endtask : check_cnt
	// one validated 0x15 request pulse, given only once the builder is idle
	task automatic req();
		for (int i = 0; i < 3000 && BUSY !== 1'b0; i++) @(posedge CLOCK);
		@(posedge CLOCK);
		#1 REQUEST = 1'b1;
		@(posedge CLOCK);
		#1 REQUEST = 1'b0;
	endtask : req
	// bounded wait for n whole frames; a short extra wait catches any surplus byte
	task automatic wait_frames(input int n);
		for (int i = 0; i < 3000 && vidr_sink_inst.cnt < base + 44 * n; i++) @(posedge CLOCK);
		repeat (20) @(posedge CLOCK);
		#1;
		check_cnt("byte count", base + 44 * n, vidr_sink_inst.cnt);
		check_cnt("last marker", base + 44 * n - 1, vidr_sink_inst.last_at);
	endtask : wait_frames
	// builds the 44 expected bytes from the field layout and compares one frame
	task automatic expect_frame(input logic [15:0] code, input logic [15:0] reason, input vidr_pci_type ids,
		input logic [31:0] maker);
		logic [319:0] v;
		logic [31:0] cs;
		v = {code, reason, 8'hf1, 8'hf2, 8'hf0, 8'h00, 24'h000000, 8'h00, FW_NAME, FW_VERSION, ids, maker};
		cs = HEADER_SUM;
		for (int i = 0; i < 20; i++) cs = cs + 32'(v[319 - 16 * i -: 16]);
		cs = -cs;
		for (int i = 0; i < 40; i++) check8("field byte", v[319 - 8 * i -: 8], vidr_sink_inst.got[base + i]);
		for (int i = 0; i < 4; i++) check8("checksum", cs[31 - 8 * i -: 8], vidr_sink_inst.got[base + 40 + i]);
		base += 44;
	endtask : expect_frame
	////////////////////////////////////////////////////////////////////////////////
	// watchdog reckoned from about 4000 cycles per frame
	initial begin
		#100000;
		num_errors++;
		give_verdict();
	end
	initial begin
		RESET = 1'b1;
		REQUEST = 1'b0;
		REQ_FAIL = 1'b0;
		FAIL_CODE = 16'h0001;
		FAIL_REASON = 16'h0002;
		FW_NAME = 96'h4142434445464700a5a5a5a5; // junk after the terminator is allowed
		FW_VERSION = 32'h010100a0;
		HOST_PCI_SHARED = 1'b0;
		FUNC_ASSIGNED = 8'h2c;
		MAKER_VALID = 1'b0;
		MAKER_NUMBER = 32'h00001234;
		HEADER_SUM = 32'h0001fffe;
		mode = 2'h2;
		for (int k = 0; k < 8; k++) FUNC_PCI_IDS[k] = {16'h1000 | 16'(k), 16'h2000 | 16'(k), 16'h3000 | 16'(k), 16'h4000 | 16'(k)};
		repeat (8) @(posedge CLOCK);
		#1 RESET = 1'b0;
		repeat (2) @(posedge CLOCK);
		#1 check8("resp type", 8'h95, RESP_TYPE);
		check8("valid idle", 8'h00, {7'h00, OUT_VALID});
		// no shared host, maker unused, slow sink; version word fixed
		req();
		wait_frames(1);
		expect_frame(16'h0000, 16'h0000, 64'h0, 32'hffffffff);
		// shared host, lowest assigned function is 2, second pulse while busy is ignored
		mode = 2'h0;
		HOST_PCI_SHARED = 1'b1;
		MAKER_VALID = 1'b1;
		req();
		for (int i = 0; i < 10 && BUSY !== 1'b1; i++) @(posedge CLOCK);
		@(posedge CLOCK);
		#1 REQUEST = 1'b1;
		@(posedge CLOCK);
		#1 REQUEST = 1'b0;
		wait_frames(1);
		expect_frame(16'h0000, 16'h0000, FUNC_PCI_IDS[2], 32'h00001234);
		// error path keeps the frame but carries the given codes; no function assigned
		REQ_FAIL = 1'b1;
		FUNC_ASSIGNED = 8'h00;
		req();
		wait_frames(1);
		expect_frame(16'h0001, 16'h0002, FUNC_PCI_IDS[0], 32'h00001234);
		// sink holds off: fifo fills and the builder stalls, then two frames drain in order
		REQ_FAIL = 1'b0;
		FUNC_ASSIGNED = 8'h81;
		mode = 2'h1;
		req();
		repeat (100) @(posedge CLOCK);
		#1 check8("busy stalled", 8'h01, {7'h00, BUSY});
		check_cnt("held count", base, vidr_sink_inst.cnt);
		mode = 2'h0;
		req();
		wait_frames(2);
		expect_frame(16'h0000, 16'h0000, FUNC_PCI_IDS[0], 32'h00001234);
		expect_frame(16'h0000, 16'h0000, FUNC_PCI_IDS[0], 32'h00001234);
		give_verdict();
	end
endmodule : tb
